// ==== rtl/stp_pkg.sv ====
// Shared constants and types of the target phase sequencer
package stp_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int DATA_W        = 8;
  localparam int CDB_REGS      = 12;
  localparam int RESEL_BYTES   = 3;
  localparam int AUTO_MSG_BYTES = 3;

  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CMD_SEND                  = 3'h1;
  localparam logic [2:0] CMD_RECEIVE               = 3'h2;
  localparam logic [2:0] CMD_AUTO_TARGET           = 3'h3;
  localparam logic [2:0] CMD_AUTO_TARGET2          = 3'h4;
  localparam logic [2:0] CMD_RECONNECT_SEND        = 3'h5;
  localparam logic [2:0] CMD_RECONNECT_RECEIVE     = 3'h6;

  // Byte count code: both bits set selects one byte
  localparam logic [1:0] BYTE_CODE_SINGLE          = 2'h3;

  // ----------------------------------------------------------------
  // Message register selects
  // ----------------------------------------------------------------
  localparam logic [1:0] MSEL_MESSAGE              = 2'h0;
  localparam logic [1:0] MSEL_TAG_FIRST            = 2'h1;
  localparam logic [1:0] MSEL_TAG_SECOND           = 2'h2;
  localparam logic [1:0] MSEL_END_STATUS           = 2'h3;

  // ----------------------------------------------------------------
  // Bus phase codes {msg, cd, io}, io set when target sends
  // ----------------------------------------------------------------
  localparam logic [2:0] PH_DATA_OUT               = 3'h0;
  localparam logic [2:0] PH_DATA_IN                = 3'h1;
  localparam logic [2:0] PH_COMMAND                = 3'h2;
  localparam logic [2:0] PH_STATUS                 = 3'h3;
  localparam logic [2:0] PH_MSG_OUT                = 3'h6;
  localparam logic [2:0] PH_MSG_IN                 = 3'h7;

  // ----------------------------------------------------------------
  // Interrupt source codes
  // ----------------------------------------------------------------
  localparam logic [7:0] INT_NONE                  = 8'h00;
  localparam logic [7:0] INT_TERM_NORMAL           = 8'h01;
  localparam logic [7:0] INT_TERM_BAD_CMD          = 8'h02;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_SELWAIT   = 9'h002,
    ST_AUTO_MSG  = 9'h004,
    ST_AUTO_CMD  = 9'h008,
    ST_STATUS    = 9'h010,
    ST_MSG_IN    = 9'h020,
    ST_RESEL_MSG = 9'h040,
    ST_DATA      = 9'h080,
    ST_DRAIN     = 9'h100
  } stp_state_t;

endpackage

// ==== rtl/stp_byte_buf.sv ====
// Byte buffer of DEPTH entries (a power of two, two by default) with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none

module stp_byte_buf #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_reset_n,
  input  wire logic         i_in_valid,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_in_ready,
  output logic              o_out_valid,
  output logic [W-1:0]      o_out_data,
  input  wire logic         i_out_ready
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("Buffer depth must be a power of two, at least two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wr_ptr;
    logic [PW-1:0]           rd_ptr;
    logic [PW:0]             cnt;
  } stp_buf_t;

  stp_buf_t r;
  stp_buf_t next_r;
  logic     push;
  logic     pop;

  assign o_in_ready  = (r.cnt != (PW+1)'(DEPTH));
  assign o_out_valid = (r.cnt != '0);
  assign o_out_data  = r.mem[r.rd_ptr];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wr_ptr] = i_in_data;
      next_r.wr_ptr        = PW'(r.wr_ptr + 1'b1);
    end
    if (pop) begin
      next_r.rd_ptr = PW'(r.rd_ptr + 1'b1);
    end
    if (push && !pop) begin
      next_r.cnt = (PW+1)'(r.cnt + 1'b1);
    end else if (pop && !push) begin
      next_r.cnt = (PW+1)'(r.cnt - 1'b1);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/stp_sequencer.sv ====
// Target-mode phase sequencer: commands, data FIFO requests and bus phases
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Mode bit picks DMA or programmed I/O for FIFO data.
// - DMA mode: request line asks for each byte, moved in order.
// - Programmed I/O: request flag asks, processor moves FIFO bytes only then.
// - Auto responder runs selection through command reception, then termination interrupt.
// - Auto responder keeps identify, two tags and the command bytes set by CDB length, twelve when that is zero or above twelve.
// - Auto completion sends end status then message register, then interrupts.
// - Reconnect send: identify, tags sent, then counted data sent from FIFO.
// - Reconnect receive: identify, tags sent, then counted data received into FIFO.
// - Every phase command ends with a termination interrupt.
module stp_sequencer
  import stp_pkg::*;
#(
  parameter int COUNT_W   = 16,
  parameter int BUF_DEPTH = 2
) (
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_reset_n,
  input  wire logic                  i_dma_mode,
  input  wire logic [3:0]            i_cdb_length,
  input  wire logic                  i_count_load,
  input  wire logic [COUNT_W-1:0]    i_count_value,
  input  wire logic                  i_cmd_valid,
  input  wire logic [2:0]            i_cmd_code,
  input  wire logic                  i_cmd_count_high,
  input  wire logic                  i_cmd_count_low,
  input  wire logic                  i_cmd_msg,
  input  wire logic                  i_cmd_cd,
  input  wire logic                  i_msg_reg_wr,
  input  wire logic [1:0]            i_msg_reg_sel,
  input  wire logic [7:0]            i_msg_reg_data,
  input  wire logic                  i_irq_clear,
  input  wire logic                  i_fifo_wr,
  input  wire logic [7:0]            i_fifo_wr_data,
  input  wire logic                  i_fifo_rd,
  input  wire logic                  i_selected,
  input  wire logic                  i_bus_rx_valid,
  input  wire logic [7:0]            i_bus_rx_data,
  input  wire logic                  i_bus_tx_ready,
  output logic                       o_bus_rx_ready,
  output logic                       o_bus_tx_valid,
  output logic [7:0]                 o_bus_tx_data,
  output logic [2:0]                 o_bus_phase,
  output logic                       o_busy,
  output logic [7:0]                 o_fifo_rd_data,
  output logic                       o_fifo_data_request,
  output logic                       o_dma_request_n,
  output logic                       o_term_irq,
  output logic [7:0]                 o_interrupt_source,
  output logic [7:0]                 o_extended_status,
  output logic [COUNT_W-1:0]         o_transfer_count,
  output logic [7:0]                 o_message,
  output logic [7:0]                 o_tag_first,
  output logic [7:0]                 o_tag_second,
  output logic [CDB_REGS*8-1:0]      o_cdb
);

  if (COUNT_W < 4) begin : g_bad_count
    $error("Counter width must be at least four bits");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    stp_state_t                st;
    logic [2:0]                cmd;
    logic                      dma;
    logic                      send_dir;
    logic [2:0]                phase;
    logic [COUNT_W-1:0]        count;
    logic [COUNT_W-1:0]        data_len;
    logic [COUNT_W-1:0]        req_left;
    logic [3:0]                idx;
    logic [7:0]                message;
    logic [7:0]                tag1;
    logic [7:0]                tag2;
    logic [7:0]                end_status;
    logic [CDB_REGS-1:0][7:0]  cdb;
    logic                      tx_valid;
    logic [7:0]                tx_data;
    logic                      rx_ready;
    logic                      ho_valid;
    logic [7:0]                ho_data;
    logic                      req;
    logic                      fifo_data_request_flag;
    logic                      dma_request_line_n;
    logic                      irq;
    logic [7:0]                int_src;
    logic [7:0]                ext_st;
    logic                      busy;
  } stp_regs_t;

  stp_regs_t r;
  stp_regs_t next_r;

  logic       buf_in_valid;
  logic [7:0] buf_in_data;
  logic       buf_in_ready;
  logic       buf_out_valid;
  logic [7:0] buf_out_data;
  logic       buf_out_ready;
  logic       tx_fire;
  logic       rx_fire;
  logic       host_wr_fire;
  logic       host_rd_fire;
  logic       tx_free;
  logic       data_st;

  // ----------------------------------------------------------------
  // Handshakes and data buffer
  // ----------------------------------------------------------------
  assign data_st       = (r.st == ST_DATA);
  assign tx_fire       = r.tx_valid && i_bus_tx_ready;
  assign rx_fire       = i_bus_rx_valid && r.rx_ready;
  assign tx_free       = !r.tx_valid || i_bus_tx_ready;
  assign host_wr_fire  = i_fifo_wr && r.req && r.send_dir && buf_in_ready;
  assign host_rd_fire  = i_fifo_rd && r.ho_valid;
  assign buf_in_valid  = data_st && (r.send_dir ? host_wr_fire : rx_fire);
  assign buf_in_data   = r.send_dir ? i_fifo_wr_data : i_bus_rx_data;
  assign buf_out_ready = r.send_dir ? (data_st && tx_free) : (!r.ho_valid || host_rd_fire);

  stp_byte_buf #(
    .W     (DATA_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .i_clk_sys   (i_clk_sys),
    .i_reset_n   (i_reset_n),
    .i_in_valid  (buf_in_valid),
    .i_in_data   (buf_in_data),
    .o_in_ready  (buf_in_ready),
    .o_out_valid (buf_out_valid),
    .o_out_data  (buf_out_data),
    .i_out_ready (buf_out_ready)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    logic [COUNT_W-1:0] len;
    logic               req_next;
    logic               term;
    len      = '0;
    req_next = 1'b0;
    term     = 1'b0;
    next_r   = r;
    if (host_rd_fire) begin
      next_r.ho_valid = 1'b0;
    end
    if (!r.send_dir && buf_out_valid && buf_out_ready) begin
      next_r.ho_valid = 1'b1;
      next_r.ho_data  = buf_out_data;
    end
    if (tx_fire || rx_fire) begin
      next_r.tx_valid = r.tx_valid && !tx_fire;
      next_r.count    = COUNT_W'(r.count - 1'b1);
    end
    if (r.send_dir && data_st && buf_out_valid && tx_free) begin
      next_r.tx_valid = 1'b1;
      next_r.tx_data  = buf_out_data;
    end
    if (host_wr_fire) begin
      next_r.req_left = COUNT_W'(r.req_left - 1'b1);
    end
    if (i_msg_reg_wr && r.st == ST_IDLE) begin
      case (i_msg_reg_sel)
        MSEL_MESSAGE:    next_r.message    = i_msg_reg_data;
        MSEL_TAG_FIRST:  next_r.tag1       = i_msg_reg_data;
        MSEL_TAG_SECOND: next_r.tag2       = i_msg_reg_data;
        default:         next_r.end_status = i_msg_reg_data;
      endcase
    end
    if (i_irq_clear) begin
      next_r.irq = 1'b0;
    end
    case (r.st)
      ST_IDLE: begin
        if (i_count_load) begin
          next_r.count = i_count_value;
        end
        if (i_cmd_valid) begin
          len = ({i_cmd_count_high, i_cmd_count_low} == BYTE_CODE_SINGLE) ?
                COUNT_W'(1) : next_r.count;
          next_r.cmd    = i_cmd_code;
          next_r.dma    = i_dma_mode;
          next_r.ext_st = {4'h0, i_dma_mode, i_cmd_code};
          next_r.busy   = 1'b1;
          next_r.idx    = '0;
          case (i_cmd_code)
            CMD_SEND, CMD_RECEIVE: begin
              next_r.send_dir = (i_cmd_code == CMD_SEND);
              next_r.phase    = {i_cmd_msg, i_cmd_cd, (i_cmd_code == CMD_SEND)};
              next_r.count    = len;
              next_r.req_left = len;
              next_r.st       = ST_DATA;
            end
            CMD_AUTO_TARGET: begin
              next_r.st = ST_SELWAIT;
            end
            CMD_AUTO_TARGET2: begin
              next_r.send_dir = 1'b1;
              next_r.phase    = PH_STATUS;
              next_r.count    = COUNT_W'(1);
              next_r.st       = ST_STATUS;
            end
            CMD_RECONNECT_SEND, CMD_RECONNECT_RECEIVE: begin
              next_r.send_dir = 1'b1;
              next_r.data_len = next_r.count;
              next_r.phase    = PH_MSG_IN;
              next_r.count    = COUNT_W'(RESEL_BYTES);
              next_r.st       = ST_RESEL_MSG;
            end
            default: begin
              next_r.busy    = 1'b0;
              next_r.irq     = 1'b1;
              next_r.int_src = INT_TERM_BAD_CMD;
            end
          endcase
        end
      end
      ST_SELWAIT: begin
        if (i_selected) begin
          next_r.send_dir = 1'b0;
          next_r.phase    = PH_MSG_OUT;
          next_r.count    = COUNT_W'(AUTO_MSG_BYTES);
          next_r.st       = ST_AUTO_MSG;
        end
      end
      ST_AUTO_MSG: begin
        if (rx_fire) begin
          next_r.idx = 4'(r.idx + 1'b1);
          case (r.idx)
            4'h0:    next_r.message = i_bus_rx_data;
            4'h1:    next_r.tag1    = i_bus_rx_data;
            default: next_r.tag2    = i_bus_rx_data;
          endcase
        end
        if (r.count == '0) begin
          next_r.phase = PH_COMMAND;
          next_r.idx   = '0;
          next_r.count = (i_cdb_length == 4'h0 || i_cdb_length > 4'(CDB_REGS)) ?
                         COUNT_W'(CDB_REGS) : COUNT_W'(i_cdb_length);
          next_r.st    = ST_AUTO_CMD;
        end
      end
      ST_AUTO_CMD: begin
        if (rx_fire) begin
          next_r.cdb[r.idx] = i_bus_rx_data;
          next_r.idx        = 4'(r.idx + 1'b1);
        end
        term = (r.count == '0);
      end
      ST_STATUS, ST_MSG_IN, ST_RESEL_MSG: begin
        if (tx_free && r.count > COUNT_W'(r.tx_valid)) begin
          next_r.tx_valid = 1'b1;
          next_r.idx      = 4'(r.idx + 1'b1);
          case (r.st)
            ST_STATUS: next_r.tx_data = r.end_status;
            ST_MSG_IN: next_r.tx_data = r.message;
            default:   next_r.tx_data = (r.idx == 4'h0) ? r.message :
                                        ((r.idx == 4'h1) ? r.tag1 : r.tag2);
          endcase
        end
        if (r.count == '0) begin
          next_r.idx = '0;
          if (r.st == ST_STATUS) begin
            next_r.phase = PH_MSG_IN;
            next_r.count = COUNT_W'(1);
            next_r.st    = ST_MSG_IN;
          end else if (r.st == ST_RESEL_MSG) begin
            next_r.send_dir = (r.cmd == CMD_RECONNECT_SEND);
            next_r.phase    = (r.cmd == CMD_RECONNECT_SEND) ? PH_DATA_IN : PH_DATA_OUT;
            next_r.count    = r.data_len;
            next_r.req_left = r.data_len;
            next_r.st       = ST_DATA;
          end else begin
            term = 1'b1;
          end
        end
      end
      ST_DATA: begin
        if (r.count == '0) begin
          if (r.send_dir) begin
            term = 1'b1;
          end else begin
            next_r.st = ST_DRAIN;
          end
        end
      end
      ST_DRAIN: begin
        term = !buf_out_valid && !r.ho_valid;
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase
    if (term) begin
      next_r.st      = ST_IDLE;
      next_r.busy    = 1'b0;
      next_r.irq     = 1'b1;
      next_r.int_src = INT_TERM_NORMAL;
    end
    req_next = next_r.send_dir ?
               (next_r.st == ST_DATA && next_r.req_left != '0 && buf_in_ready && !host_wr_fire) :
               next_r.ho_valid;
    next_r.req      = req_next;
    next_r.fifo_data_request_flag      = req_next && !next_r.dma;
    next_r.dma_request_line_n  = !(req_next && next_r.dma);
    next_r.rx_ready = (next_r.st == ST_AUTO_MSG || next_r.st == ST_AUTO_CMD ||
                       (next_r.st == ST_DATA && !next_r.send_dir)) &&
                      next_r.count != '0 && !rx_fire &&
                      (next_r.st != ST_DATA || buf_in_ready);
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      r         <= '0;
      r.st      <= ST_IDLE;
      r.dma_request_line_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_bus_rx_ready      = r.rx_ready;
  assign o_bus_tx_valid      = r.tx_valid;
  assign o_bus_tx_data       = r.tx_data;
  assign o_bus_phase         = r.phase;
  assign o_busy              = r.busy;
  assign o_fifo_rd_data      = r.ho_data;
  assign o_fifo_data_request = r.fifo_data_request_flag;
  assign o_dma_request_n     = r.dma_request_line_n;
  assign o_term_irq          = r.irq;
  assign o_interrupt_source  = r.int_src;
  assign o_extended_status   = r.ext_st;
  assign o_transfer_count    = r.count;
  assign o_message           = r.message;
  assign o_tag_first         = r.tag1;
  assign o_tag_second        = r.tag2;
  assign o_cdb               = r.cdb;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  chk_mode_exclusive: assert property (!(o_fifo_data_request && !o_dma_request_n))
    else $error("Both request kinds active");
  chk_dma_line_mode: assert property (!o_dma_request_n |-> r.dma)
    else $error("DMA request outside DMA mode");
  chk_pio_flag_mode: assert property (o_fifo_data_request |-> !r.dma && (data_st || r.st == ST_DRAIN))
    else $error("Data request flag outside transfer");
  chk_auto_entry: assert property (r.st == ST_SELWAIT && i_selected |=> r.st == ST_AUTO_MSG && o_bus_phase == PH_MSG_OUT)
    else $error("Selection did not start message phase");
  chk_identify_kept: assert property (r.st == ST_AUTO_MSG && rx_fire && r.idx == 4'h0
    |=> o_message == $past(i_bus_rx_data))
    else $error("Identify byte not stored");
  chk_status_byte: assert property (r.st == ST_STATUS && o_bus_tx_valid |-> o_bus_tx_data == r.end_status)
    else $error("Status phase sent wrong byte");
  chk_resel_first: assert property (r.st == ST_RESEL_MSG && tx_fire && r.count == COUNT_W'(RESEL_BYTES)
    |-> o_bus_tx_data == r.message)
    else $error("Reconnect did not start with identify");
  chk_term_irq: assert property ($fell(o_busy) |-> o_term_irq && o_interrupt_source != INT_NONE)
    else $error("Command ended without interrupt");
  chk_count_step: assert property (data_st && tx_fire |=> o_transfer_count == $past(o_transfer_count) - 1'b1)
    else $error("Counter did not step per byte");
  chk_req_stop: assert property (r.req && r.send_dir |-> r.req_left != '0)
    else $error("Request issued with nothing left");

  cov_auto_target: cover property (o_term_irq && r.cmd == CMD_AUTO_TARGET && !o_busy);
  cov_dma_send: cover property (host_wr_fire && r.dma);
  cov_buf_full: cover property (!buf_in_ready && data_st);
  cov_resel_recv: cover property (r.st == ST_DRAIN && r.cmd == CMD_RECONNECT_RECEIVE);

endmodule

`default_nettype wire

// ==== bench/stp_init_model.sv ====
// Initiator model on the bus side of the sequencer
`timescale 1ns/100ps
`default_nettype none
module stp_init_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rx_ready,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  output logic            o_tx_ready
);
  logic [7:0] nxt = 8'h40;
  logic [7:0] got[$];
  logic       slow = 1'b0;
  // Takes sent bytes on alternate cycles only, offers a rising byte series
  always @(posedge i_clk_sys) begin
    slow <= ~slow;
    if (o_tx_ready && i_tx_valid) got.push_back(i_tx_data);
    if (i_rx_ready) nxt <= nxt + 8'h01;
  end
  assign o_tx_ready = slow;
  assign o_rx_valid = 1'b1;
  assign o_rx_data  = nxt;
endmodule
`default_nettype wire

// ==== bench/test_stp_sequencer.sv ====
// Self-checking bench of the target phase sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
  $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module test_stp_sequencer import stp_pkg::*; ;
  logic i_clk_sys = 0, i_reset_n = 0, i_dma_mode = 0, i_count_load = 0, i_cmd_valid = 0, i_selected = 0;
  logic i_cmd_count_high = 0, i_cmd_count_low = 0, i_cmd_msg = 0, i_cmd_cd = 0, i_msg_reg_wr = 0;
  logic i_irq_clear = 0, i_fifo_wr = 0, i_fifo_rd = 0, i_bus_rx_valid, i_bus_tx_ready;
  logic o_bus_rx_ready, o_bus_tx_valid, o_busy, o_fifo_data_request, o_dma_request_n, o_term_irq;
  logic [3:0] i_cdb_length = 4'h0;
  logic [2:0] i_cmd_code = 3'h0, o_bus_phase;
  logic [1:0] i_msg_reg_sel = 2'h0;
  logic [7:0] i_msg_reg_data = 8'h0, i_fifo_wr_data = 8'h0, i_bus_rx_data, o_bus_tx_data, o_fifo_rd_data;
  logic [7:0] o_interrupt_source, o_extended_status, o_message, o_tag_first, o_tag_second, b0, r0;
  logic [15:0] i_count_value = 16'h0, o_transfer_count;
  logic [95:0] o_cdb;
  logic [31:0] seed = 32'h8f34;
  logic [7:0] txq[$];
  int mismatches = 0, comparisons = 0;
  stp_sequencer i_stp_sequencer (.*);
  stp_init_model i_stp_init_model (.i_clk_sys, .i_rx_ready(o_bus_rx_ready), .i_tx_valid(o_bus_tx_valid),
    .i_tx_data(o_bus_tx_data), .o_rx_valid(i_bus_rx_valid), .o_rx_data(i_bus_rx_data), .o_tx_ready(i_bus_tx_ready));
  always #5 i_clk_sys = ~i_clk_sys;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic mreg(input logic [1:0] s, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_msg_reg_wr <= 1;
    i_msg_reg_sel <= s;
    i_msg_reg_data <= d;
    @(posedge i_clk_sys);
    i_msg_reg_wr <= 0;
  endtask
  // Issue a command, move n FIFO bytes on request, wait for termination
  task automatic run(input logic [2:0] c, input logic [3:0] f, input int n, input logic rx);
    int k, gap;
    k = 0;
    gap = 0;
    r0 = i_stp_init_model.nxt;
    @(posedge i_clk_sys);
    i_count_load <= 1;
    i_count_value <= (f[3:2] == 2'h3) ? 16'h5 : 16'(n);
    i_cmd_valid <= 1;
    i_cmd_code <= c;
    {i_cmd_count_high, i_cmd_count_low, i_cmd_msg, i_cmd_cd} <= f;
    i_dma_mode <= rnd() > 8'h7f;
    @(posedge i_clk_sys);
    i_count_load <= 0;
    i_cmd_valid <= 0;
    i_selected <= (c == CMD_AUTO_TARGET);
    for (int t = 0; t < 3000 && !o_term_irq; t++) begin
      @(posedge i_clk_sys);
      i_selected <= 0;
      if (t == 0 && c < 3'h3) `CHK(o_bus_phase, {f[1:0], c == CMD_SEND})
      if (gap > 0) begin
        gap--;
        i_fifo_wr <= 0;
        i_fifo_rd <= 0;
      end else if (i_dma_mode ? !o_dma_request_n : o_fifo_data_request) begin
        k++;
        gap = 2;
        if (rx) begin
          `CHK(o_fifo_rd_data, r0)
          r0++;
          i_fifo_rd <= 1;
        end else begin
          b0 = rnd();
          txq.push_back(b0);
          i_fifo_wr <= 1;
          i_fifo_wr_data <= b0;
        end
      end
    end
    if (!o_term_irq) begin
      mismatches++;
      end_of_test();
    end
    `CHK(o_interrupt_source, INT_TERM_NORMAL)
    `CHK(o_busy, 1'b0)
    `CHK(o_extended_status, {4'h0, i_dma_mode, c})
    `CHK(o_transfer_count, 16'h0)
    `CHK(k, n)
    `CHK(i_stp_init_model.got.size(), txq.size())
    foreach (txq[i]) `CHK(i_stp_init_model.got[i], txq[i])
    i_stp_init_model.got.delete();
    txq.delete();
    i_irq_clear <= 1;
    @(posedge i_clk_sys);
    i_irq_clear <= 0;
    $display("test of command %0d done", c);
  endtask
  initial begin
    logic [7:0] m[3];
    logic [14:0][7:0] ex;
    repeat (5) @(posedge i_clk_sys);
    i_reset_n <= 1;
    repeat (3) begin
      run(CMD_SEND, 4'h0, 3, 0);
      run(CMD_RECEIVE, 4'h0, 3, 1);
    end
    run(CMD_SEND, 4'hd, 1, 0);
    run(CMD_SEND, 4'h3, 2, 0);
    mreg(MSEL_END_STATUS, 8'h02);
    mreg(MSEL_MESSAGE, 8'h00);
    txq = {8'h02, 8'h00};
    run(CMD_AUTO_TARGET2, 4'h0, 0, 0);
    b0 = i_stp_init_model.nxt;
    run(CMD_AUTO_TARGET, 4'h0, 0, 1);
    foreach (ex[j]) ex[j] = b0 + 8'(j);
    `CHK({o_cdb, o_tag_second, o_tag_first, o_message}, ex)
    foreach (m[i]) m[i] = rnd();
    mreg(MSEL_MESSAGE, m[0]);
    mreg(MSEL_TAG_FIRST, m[1]);
    mreg(MSEL_TAG_SECOND, m[2]);
    for (int i = 0; i < 2; i++) begin
      txq = {m[0], m[1], m[2]};
      run(i ? CMD_RECONNECT_RECEIVE : CMD_RECONNECT_SEND, 4'h0, 2, i[0]);
    end
    @(posedge i_clk_sys);
    i_cmd_valid <= 1;
    i_cmd_code <= 3'h7;
    @(posedge i_clk_sys);
    i_cmd_valid <= 0;
    @(posedge i_clk_sys);
    `CHK({o_term_irq, o_busy, o_interrupt_source}, {2'h2, INT_TERM_BAD_CMD})
    $display("test of bad command done");
    end_of_test();
  end
endmodule
`default_nettype wire
